// ==== inc/opu_regs.vh ====
// Register offsets, field positions, reset values and timing counts for the pixel unpacker
`ifndef OPU_REGS_VH
`define OPU_REGS_VH

// Printed offsets are register indices; byte address is four times the index
`define OPU_IDX_MEM_TYPE 8'he0
`define OPU_IDX_TIMING_A 8'he1
`define OPU_IDX_TIMING_B 8'he2
`define OPU_IDX_TIMING_C 8'he3
`define OPU_IDX_INIT_CTRL 8'he4
`define OPU_ADDR_MEM_TYPE 12'h380
`define OPU_ADDR_TIMING_A 12'h384
`define OPU_ADDR_TIMING_B 12'h388
`define OPU_ADDR_TIMING_C 12'h38c
`define OPU_ADDR_INIT_CTRL 12'h390

// Block's own registers
`define OPU_ADDR_MODE 12'h000
`define OPU_ADDR_PIXEL 12'h004
`define OPU_ADDR_PALETTE 12'h008
`define OPU_ADDR_PIX_ADDR 12'h00c
`define OPU_ADDR_IRQ_STATUS 12'h010
`define OPU_ADDR_IRQ_MASK 12'h014

// Mode register fields
`define OPU_MODE_BUS16 0
`define OPU_MODE_NIBBLE 1

// Init control field
`define OPU_INIT_BIT 0

// Interrupt status bits
`define OPU_IRQ_INIT_DONE 0
`define OPU_IRQ_PIXEL 1
`define OPU_IRQ_EARLY 2

// Palette write fields
`define OPU_PAL_IDX_LSB 16
`define OPU_PAL_IDX_MSB 21

// Reset values
`define OPU_RST_BYTE 8'h00
`define OPU_RST_MODE 2'h0
`define OPU_RST_MASK 3'h0
`define OPU_RST_TIMING_B 8'ha1
`define OPU_RST_TIMING_C 8'h07

// Opacity scale, full opacity in thirty-seconds
`define OPU_ALPHA_FULL 6'h20
`define OPU_ALPHA_HIGH 6'h14
`define OPU_ALPHA_LOW 6'h0b

// Timing
`define OPU_CLK_MHZ 250
`define OPU_INIT_TIME_US 100
`define OPU_FRAME_WORDS 1310720

`endif

// ==== logic/opu_alpha_decode.v ====
// Opacity code to thirty-seconds decoder
`timescale 1ns/1ps
`include "opu_regs.vh"
module opu_alpha_decode (
  input wire wide,
  input wire rising,
  input wire [3:0] code,
  output reg [5:0] alpha
);
  always @* begin
    alpha = 6'h00;
    if (!wide) begin
      case (code[1:0])
        2'h0: alpha = rising ? 6'h00 : `OPU_ALPHA_FULL;
        2'h1: alpha = rising ? `OPU_ALPHA_LOW : `OPU_ALPHA_HIGH;
        2'h2: alpha = rising ? `OPU_ALPHA_HIGH : `OPU_ALPHA_LOW;
        default: alpha = rising ? `OPU_ALPHA_FULL : 6'h00;
      endcase
    end else if (rising) begin
      // Code 15 jumps to full, not 30/32
      alpha = (code == 4'hf) ? `OPU_ALPHA_FULL : {1'b0, code, 1'b0};
    end else begin
      alpha = (code == 4'hf) ? 6'h00 : (`OPU_ALPHA_FULL - {1'b0, code, 1'b0});
    end
  end
endmodule

// ==== logic/opu_scan_reader.v ====
// Scan-out fetch engine reading display memory toward the panel
`timescale 1ns/1ps
`include "opu_regs.vh"
module opu_scan_reader #(
  parameter FRAME_WORDS = `OPU_FRAME_WORDS
) (
  input wire pclk,
  input wire presetn,
  input wire enable,
  output wire rd_req,
  input wire rd_ack,
  output reg [23:0] rd_addr,
  input wire rd_valid,
  input wire [17:0] rd_data,
  output reg panel_valid,
  output reg [17:0] panel_data
);
  localparam integer LAST_INT = FRAME_WORDS - 1;
  localparam [23:0] LAST_WORD = LAST_INT[23:0];

  // Runs regardless of host pixel writes; memory arbitrates
  assign rd_req = enable;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_addr <= 24'h000000;
      panel_valid <= 1'b0;
      panel_data <= 18'h00000;
    end else begin
      panel_valid <= rd_valid;
      if (rd_valid) begin
        panel_data <= rd_data;
      end
      if (!enable) begin
        rd_addr <= 24'h000000;
      end else if (rd_ack) begin
        rd_addr <= (rd_addr == LAST_WORD) ? 24'h000000 : rd_addr + 24'h000001;
      end
    end
  end
endmodule

// ==== logic/opu_unpacker.v ====
// Opacity pixel unpacker with display memory start-up and APB registers
// How it works
// - a 64-entry palette of 12-bit colours, selected by the pixel's index
// - 8-bit indexed mode takes one pixel per byte, opacity 7:6, index 5:0
// - 8-bit indexed opacity code 0 full, 1 20/32, 2 11/32, 3 clear
// - 8-bit nibble mode: green/blue byte first, then opacity/red byte
// - 8-bit nibble opacity 0 full, minus 2/32 per step, 15 clear
// - 16-bit indexed word uses low byte; code 0 clear up to 3 full
// - 16-bit nibble word holds opacity, red, green, blue high to low
// - 16-bit nibble opacity 0 clear, plus 2/32 per step, 15 full
// - scan-out keeps fetching memory for the panel, independent of host writes
// - host sets timing registers; device refreshes at the configured interval
// - writing one to init control bit 0 starts memory initialisation
// - init control bit 0 reads one once initialisation has completed
`timescale 1ns/1ps
`include "opu_regs.vh"
module opu_unpacker #(
  parameter INIT_CYCLES = `OPU_INIT_TIME_US * `OPU_CLK_MHZ,
  parameter FRAME_WORDS = `OPU_FRAME_WORDS
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire irq,
  output reg mem_wr_req,
  input wire mem_wr_ready,
  output reg [23:0] mem_wr_addr,
  output reg [17:0] mem_wr_data,
  output reg [7:0] mem_type,
  output wire [7:0] mem_timing_a,
  output reg mem_init_busy,
  output reg mem_refresh,
  output wire rd_req,
  input wire rd_ack,
  output wire [23:0] rd_addr,
  input wire rd_valid,
  input wire [17:0] rd_data,
  output wire panel_valid,
  output wire [17:0] panel_data
);
  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_BUSY = 3'b010;
  localparam [2:0] S_DONE = 3'b100;
  localparam [31:0] INIT_LAST = INIT_CYCLES - 1;

  reg [7:0] timing_a;
  reg [7:0] timing_b;
  reg [7:0] timing_c;
  reg [1:0] mode;
  reg [11:0] palette [0:63];
  reg [5:0] pal_sel;
  reg [2:0] irq_status;
  reg [2:0] irq_mask;
  reg [2:0] state;
  reg [31:0] init_count;
  reg [15:0] refresh_count;
  reg byte_phase;
  reg [7:0] first_byte;
  reg [5:0] idx_i;

  wire bus16 = mode[`OPU_MODE_BUS16];
  wire nibble = mode[`OPU_MODE_NIBBLE];
  // Only the 8-bit nibble path splits one pixel over two writes
  wire nibble8 = nibble && !bus16;
  wire access = psel && penable;
  wire hit_pixel = paddr == `OPU_ADDR_PIXEL;
  wire wr_pixel = access && pwrite && hit_pixel && pready;
  wire init_done = state == S_DONE;
  wire mapped = paddr == `OPU_ADDR_MEM_TYPE || paddr == `OPU_ADDR_TIMING_A ||
                paddr == `OPU_ADDR_TIMING_B || paddr == `OPU_ADDR_TIMING_C ||
                paddr == `OPU_ADDR_INIT_CTRL || paddr == `OPU_ADDR_MODE ||
                hit_pixel || paddr == `OPU_ADDR_PALETTE ||
                paddr == `OPU_ADDR_PIX_ADDR || paddr == `OPU_ADDR_IRQ_STATUS ||
                paddr == `OPU_ADDR_IRQ_MASK;
  wire wr_ok = access && pwrite && mapped && pready;

  // Pixel write stalls the bus while the previous pixel is still unsent
  // Trade-off: no pixel buffer, so a slow memory costs bus time
  assign pready = !(psel && pwrite && hit_pixel && mem_wr_req);
  assign pslverr = access && !mapped;
  assign irq = |(irq_status & irq_mask);
  assign mem_timing_a = timing_a;

  // Pixel decode from the current bus word
  reg [3:0] code;
  reg [11:0] color;
  reg make_pixel;
  wire [5:0] alpha;

  always @* begin
    idx_i = pwdata[5:0];
    code = 4'h0;
    color = 12'h000;
    make_pixel = 1'b0;
    if (!nibble) begin
      code = {2'b00, pwdata[7:6]};
      color = palette[idx_i];
      make_pixel = 1'b1;
    end else if (bus16) begin
      code = pwdata[15:12];
      color = pwdata[11:0];
      make_pixel = 1'b1;
    end else begin
      code = pwdata[7:4];
      color = {pwdata[3:0], first_byte};
      make_pixel = byte_phase;
    end
  end

  opu_alpha_decode u_alpha (
    .wide(nibble),
    .rising(bus16),
    .code(code),
    .alpha(alpha)
  );

  // Register writes
  integer i;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_type <= `OPU_RST_BYTE;
      timing_a <= `OPU_RST_BYTE;
      timing_b <= `OPU_RST_TIMING_B;
      timing_c <= `OPU_RST_TIMING_C;
      mode <= `OPU_RST_MODE;
      irq_mask <= `OPU_RST_MASK;
      pal_sel <= 6'h00;
      for (i = 0; i < 64; i = i + 1) begin
        palette[i] <= 12'h000;
      end
    end else if (wr_ok) begin
      case (paddr)
        `OPU_ADDR_MEM_TYPE: mem_type <= pwdata[7:0];
        `OPU_ADDR_TIMING_A: timing_a <= pwdata[7:0];
        `OPU_ADDR_TIMING_B: timing_b <= pwdata[7:0];
        `OPU_ADDR_TIMING_C: timing_c <= pwdata[7:0];
        `OPU_ADDR_MODE: mode <= pwdata[1:0];
        `OPU_ADDR_IRQ_MASK: irq_mask <= pwdata[2:0];
        `OPU_ADDR_PALETTE: begin
          // Index above the colour, so one write loads a whole entry
          pal_sel <= pwdata[`OPU_PAL_IDX_MSB:`OPU_PAL_IDX_LSB];
          palette[pwdata[`OPU_PAL_IDX_MSB:`OPU_PAL_IDX_LSB]] <= pwdata[11:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Byte phase and pixel output toward display memory
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_phase <= 1'b0;
      first_byte <= 8'h00;
      mem_wr_req <= 1'b0;
      mem_wr_addr <= 24'h000000;
      mem_wr_data <= 18'h00000;
    end else begin
      if (mem_wr_req && mem_wr_ready) begin
        mem_wr_req <= 1'b0;
        mem_wr_addr <= mem_wr_addr + 24'h000001;
      end
      if (wr_ok && paddr == `OPU_ADDR_PIX_ADDR) begin
        mem_wr_addr <= pwdata[23:0];
      end
      if (wr_ok && paddr == `OPU_ADDR_MODE) begin
        byte_phase <= 1'b0;
      end else if (wr_pixel && nibble8) begin
        byte_phase <= !byte_phase;
        if (!byte_phase) begin
          first_byte <= pwdata[7:0];
        end
      end
      // Pixels before memory start-up are dropped and flagged
      if (wr_pixel && make_pixel && init_done) begin
        mem_wr_req <= 1'b1;
        mem_wr_data <= {alpha, color};
      end
    end
  end

  // Memory start-up sequence
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      init_count <= 32'h00000000;
      mem_init_busy <= 1'b0;
    end else begin
      case (state)
        S_IDLE, S_DONE: begin
          if (wr_ok && paddr == `OPU_ADDR_INIT_CTRL && pwdata[`OPU_INIT_BIT]) begin
            state <= S_BUSY;
            init_count <= 32'h00000000;
            mem_init_busy <= 1'b1;
          end
        end
        S_BUSY: begin
          if (init_count == INIT_LAST) begin
            state <= S_DONE;
            mem_init_busy <= 1'b0;
          end else begin
            init_count <= init_count + 32'h00000001;
          end
        end
        default: begin
          state <= S_IDLE;
          mem_init_busy <= 1'b0;
        end
      endcase
    end
  end

  // Refresh tick every {timing_c, timing_b} cycles once memory is up
  // Zero interval degrades to a tick every cycle rather than never
  wire [15:0] refresh_interval = {timing_c, timing_b};
  wire [15:0] refresh_next = refresh_count + 16'h0001;
  wire refresh_end = refresh_next >= refresh_interval;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refresh_count <= 16'h0000;
      mem_refresh <= 1'b0;
    end else begin
      mem_refresh <= 1'b0;
      if (!init_done) begin
        refresh_count <= 16'h0000;
      end else if (refresh_end) begin
        refresh_count <= 16'h0000;
        mem_refresh <= 1'b1;
      end else begin
        refresh_count <= refresh_next;
      end
    end
  end

  // Sticky events; a new event outranks a same-cycle clear
  wire [2:0] events;
  assign events[`OPU_IRQ_INIT_DONE] = state == S_BUSY && init_count == INIT_LAST;
  assign events[`OPU_IRQ_PIXEL] = wr_pixel && make_pixel && init_done;
  assign events[`OPU_IRQ_EARLY] = wr_pixel && !init_done;
  wire [2:0] clears = (wr_ok && paddr == `OPU_ADDR_IRQ_STATUS) ? pwdata[2:0] : 3'h0;
  reg [2:0] next_irq_status;

  always @* begin
    next_irq_status = irq_status & ~clears;
    next_irq_status = next_irq_status | events;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 3'h0;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // Read mux
  always @* begin
    prdata = 32'h00000000;
    if (psel && !pwrite) begin
      case (paddr)
        `OPU_ADDR_MEM_TYPE: prdata = {24'h000000, mem_type};
        `OPU_ADDR_TIMING_A: prdata = {24'h000000, timing_a};
        `OPU_ADDR_TIMING_B: prdata = {24'h000000, timing_b};
        `OPU_ADDR_TIMING_C: prdata = {24'h000000, timing_c};
        `OPU_ADDR_INIT_CTRL: prdata = {31'h00000000, init_done};
        `OPU_ADDR_MODE: prdata = {29'h00000000, byte_phase, mode};
        `OPU_ADDR_PALETTE: prdata = {10'h000, pal_sel, 4'h0, palette[pal_sel]};
        `OPU_ADDR_PIX_ADDR: prdata = {8'h00, mem_wr_addr};
        `OPU_ADDR_IRQ_STATUS: prdata = {29'h00000000, irq_status};
        `OPU_ADDR_IRQ_MASK: prdata = {29'h00000000, irq_mask};
        default: prdata = 32'h00000000;
      endcase
    end
  end

  opu_scan_reader #(
    .FRAME_WORDS(FRAME_WORDS)
  ) u_scan (
    .pclk(pclk),
    .presetn(presetn),
    .enable(init_done),
    .rd_req(rd_req),
    .rd_ack(rd_ack),
    .rd_addr(rd_addr),
    .rd_valid(rd_valid),
    .rd_data(rd_data),
    .panel_valid(panel_valid),
    .panel_data(panel_data)
  );
endmodule

// ==== sim/opu_mem_model.sv ====
// Display memory model: stalling write port and scan read return
`timescale 1ns/1ps
module opu_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_wr_req,
  input wire logic [17:0] mem_wr_data,
  output logic mem_wr_ready,
  input wire logic rd_req,
  output logic rd_ack,
  output logic rd_valid,
  output logic [17:0] rd_data
);
  logic [17:0] got [$];
  // Ready drops at random so pixel writes meet a busy memory
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_wr_ready <= 1'b0;
      rd_ack <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 18'h0;
    end else begin
      if (mem_wr_req && mem_wr_ready) got.push_back(mem_wr_data);
      mem_wr_ready <= $urandom_range(0, 2) != 0;
      rd_ack <= rd_req && $urandom_range(0, 1);
      rd_valid <= rd_ack;
      // Idle data toggles so stale values never look valid
      rd_data <= rd_ack ? 18'h3ffff & $urandom : ~rd_data;
    end
  end
endmodule

// ==== sim/opu_unpacker_chk.sv ====
// Port checker for the opacity pixel unpacker
`timescale 1ns/1ps
module opu_unpacker_chk #(
  parameter FRAME_WORDS = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic mem_wr_req,
  input wire logic mem_wr_ready,
  input wire logic [23:0] mem_wr_addr,
  input wire logic [17:0] mem_wr_data,
  input wire logic mem_init_busy,
  input wire logic mem_refresh,
  input wire logic rd_req,
  input wire logic rd_ack,
  input wire logic [23:0] rd_addr,
  input wire logic rd_valid,
  input wire logic [17:0] rd_data,
  input wire logic panel_valid,
  input wire logic [17:0] panel_data
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_pend; mem_wr_req && !mem_wr_ready; endsequence
  sequence s_take; mem_wr_req && mem_wr_ready; endsequence
  sequence s_busy; mem_init_busy[*6] ##[1:4] !mem_init_busy; endsequence
  property p_hold; s_pend |=> mem_wr_req && $stable(mem_wr_data) && $stable(mem_wr_addr);
  endproperty
  property p_step; s_take |=> !mem_wr_req && mem_wr_addr == $past(mem_wr_addr) + 24'h1;
  endproperty
  property p_early; mem_wr_req |-> rd_req; endproperty
  property p_stall; !pready |-> psel && pwrite && paddr == 12'h004 && mem_wr_req; endproperty
  property p_init; $rose(mem_init_busy) |-> s_busy; endproperty
  property p_busy; mem_init_busy |-> !rd_req; endproperty
  property p_ref; mem_refresh |-> rd_req ##1 !mem_refresh[*8]; endproperty
  property p_scan; rd_req && rd_ack |=> rd_addr ==
    (($past(rd_addr) == FRAME_WORDS - 1) ? 24'h0 : $past(rd_addr) + 24'h1); endproperty
  property p_pass; rd_valid |=> panel_valid && panel_data == $past(rd_data); endproperty
  a_hold: assert property (p_hold) else $error("pixel request changed while stalled");
  a_step: assert property (p_step) else $error("pixel address did not advance");
  a_early: assert property (p_early) else $error("pixel sent before memory ready");
  a_stall: assert property (p_stall) else $error("unexpected bus wait");
  a_init: assert property (p_init) else $error("init busy length wrong");
  a_busy: assert property (p_busy) else $error("scan active during init");
  a_ref: assert property (p_ref) else $error("refresh pulse misplaced");
  a_scan: assert property (p_scan) else $error("scan address step wrong");
  a_pass: assert property (p_pass) else $error("panel data not forwarded");
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench for the opacity pixel unpacker
`timescale 1ns/1ps
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, irq, mem_wr_req, mem_wr_ready, rd_req, rd_ack, rd_valid;
  logic [17:0] mem_wr_data, rd_data;
  logic [7:0] ty, ty_o, ta;
  logic rf;
  int gap;
  logic [15:0] w;
  logic [11:0] pal [64];
  logic [17:0] expq [$];
  int n_errors = 0, checks_done = 0;
  always #2 pclk = ~pclk;
  opu_unpacker #(.INIT_CYCLES(8), .FRAME_WORDS(16)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .mem_wr_req(mem_wr_req), .mem_wr_ready(mem_wr_ready), .mem_wr_addr(),
    .mem_wr_data(mem_wr_data), .mem_type(ty_o), .mem_timing_a(ta), .mem_init_busy(),
    .mem_refresh(rf), .rd_req(rd_req), .rd_ack(rd_ack), .rd_addr(), .rd_valid(rd_valid),
    .rd_data(rd_data), .panel_valid(), .panel_data());
  opu_mem_model u_mem (.pclk(pclk), .presetn(presetn), .mem_wr_req(mem_wr_req),
    .mem_wr_data(mem_wr_data), .mem_wr_ready(mem_wr_ready), .rd_req(rd_req),
    .rd_ack(rd_ack), .rd_valid(rd_valid), .rd_data(rd_data));
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, s, x);
    end
  endtask
  // One idle cycle after each transfer keeps drivers single-assigned
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    if (n >= 50) n_errors++;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  function automatic logic [5:0] t2(input logic [1:0] c);
    return c == 0 ? 6'h20 : c == 1 ? 6'h14 : c == 2 ? 6'h0b : 6'h00;
  endfunction
  function automatic logic [17:0] ex(input logic [1:0] m, input logic [15:0] v);
    logic [3:0] a;
    a = v[15:12];
    case (m)
      0: return {t2(v[7:6]), pal[v[5:0]]};
      1: return {t2(~v[7:6]), pal[v[5:0]]};
      2: return {a == 15 ? 6'h00 : 6'h20 - {a, 1'b0}, v[11:0]};
      default: return {a == 15 ? 6'h20 : {1'b0, a, 1'b0}, v[11:0]};
    endcase
  endfunction
  task automatic pix(input logic [1:0] m, input logic [15:0] v);
    expq.push_back(ex(m, v));
    if (m == 2) begin
      apb(1, 12'h004, {24'h0, v[7:0]});
      apb(1, 12'h004, {24'h0, v[15:8]});
    end else apb(1, 12'h004, {16'h0, v});
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #60000;
    n_errors++;
    summarize;
  end
  initial begin
    void'($urandom(13));
    repeat (3) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h388, 0);
    chk(r, 32'ha1);
    apb(0, 12'h3fc, 0);
    chk({r[30:0], e}, 1);
    apb(1, 12'h014, 7);
    apb(1, 12'h004, 8'h3f);
    chk(irq, 1);
    apb(0, 12'h010, 0);
    chk(r, 4);
    apb(1, 12'h010, 4);
    chk(irq, 0);
    $display("test early pixel done");
    ty = $urandom;
    apb(1, 12'h380, ty);
    chk(ty_o, ty);
    apb(1, 12'h384, 3);
    chk(ta, 3);
    apb(1, 12'h388, 16);
    apb(1, 12'h38c, 0);
    apb(1, 12'h390, 1);
    apb(0, 12'h390, 0);
    chk(r[0], 0);
    for (int i = 0; i < 40 && r[0] !== 1'b1; i++) apb(0, 12'h390, 0);
    chk(r[0], 1);
    chk(irq, 1);
    apb(1, 12'h014, 6);
    chk(irq, 0);
    apb(1, 12'h010, 7);
    chk(rd_req, 1);
    @(posedge pclk iff rf === 1'b1);
    gap = 0;
    do begin
      @(posedge pclk);
      gap++;
    end while (rf !== 1'b1 && gap < 40);
    chk(gap, 16);
    $display("test init done");
    for (int i = 0; i < 64; i++) begin
      pal[i] = $urandom;
      apb(1, 12'h008, {10'h0, i[5:0], 4'h0, pal[i]});
    end
    for (int m = 0; m < 4; m++) begin
      apb(1, 12'h000, m);
      if (m == 2) begin
        apb(1, 12'h004, 8'h5a);
        apb(0, 12'h000, 0);
        chk(r[2], 1);
        apb(1, 12'h000, m);
        apb(0, 12'h000, 0);
        chk(r[2], 0);
      end
      for (int k = 0; k < 8; k++) begin
        w = $urandom;
        if (k < 4) w[7:6] = k[1:0];
        if (k < 2) w[15:12] = {4{k[0]}};
        if (k == 2) w[15:12] = 4'he;
        if (m == 0) w[15:8] = 8'h00;
        pix(m[1:0], w);
      end
      $display("test mode %0d done", m);
    end
    for (int i = 0; i < 50 && mem_wr_req !== 1'b0; i++) @(posedge pclk);
    chk(u_mem.got.size(), expq.size());
    foreach (expq[i]) chk(u_mem.got[i], expq[i]);
    $display("test pixel stream done");
    summarize;
  end
endmodule
bind opu_unpacker opu_unpacker_chk #(.FRAME_WORDS(FRAME_WORDS)) u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .pwrite(pwrite), .paddr(paddr), .pready(pready),
  .mem_wr_req(mem_wr_req), .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr),
  .mem_wr_data(mem_wr_data), .mem_init_busy(mem_init_busy), .mem_refresh(mem_refresh),
  .rd_req(rd_req), .rd_ack(rd_ack), .rd_addr(rd_addr), .rd_valid(rd_valid),
  .rd_data(rd_data), .panel_valid(panel_valid), .panel_data(panel_data));
